// File: dv/abam_core_model.sv
// Core model that issues operand requests.
`timescale 1ns/1ps
`default_nettype none
module abam_core_model (
	input wire logic core_clk,
	output var abam_pkg::abam_req_s req
);
	initial req = '0;
	// Falling-edge updates keep requests settled at the core edge.
	task automatic put(input abam_pkg::abam_req_s r);
		@(negedge core_clk);
		req = r;
	endtask : put
endmodule : abam_core_model
`default_nettype wire

// File: dv/abam_mapper_props.sv
// Port assertions for the mapper.
`timescale 1ns/1ps
`default_nettype none
module abam_mapper_props (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire abam_pkg::abam_req_s req,
	input wire abam_pkg::abam_bank_t bank_select_value,
	input wire logic extended_instruction_set_enable,
	input wire abam_pkg::abam_bank_t index_bank,
	input wire abam_pkg::abam_addr_t data_addr,
	input wire logic rvalid
);
	wire logic v = req.valid;
	wire logic s = v && req.access_sel;
	wire logic a = v && !req.access_sel;
	wire logic lo = a && !extended_instruction_set_enable && req.offset < 8'h60;
	wire logic xl = a && extended_instruction_set_enable && req.offset < 8'h60;
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	a_low_region: assert property (lo |=> data_addr[11:8] == 4'h0) else $error("low");
	a_high_region: assert property (a && req.offset > 8'h5f |=> data_addr[11:8] == 4'hf) else $error("high");
	a_linear_offset: assert property (v |=> data_addr[7:0] == $past(req.offset)) else $error("offset");
	a_banked_addr: assert property (s |=> data_addr == {$past(bank_select_value), $past(req.offset)})
		else $error("bank");
	a_read_pulse: assert property (v && !req.write |=> rvalid) else $error("rvalid");
	a_write_quiet: assert property (v && req.write |=> !rvalid) else $error("write");
	a_idle_quiet: assert property (!v |=> !rvalid) else $error("idle");
	a_addr_hold: assert property (!v |=> $stable(data_addr)) else $error("hold");
	a_ext_region: assert property (xl |=> data_addr[11:8] == $past(index_bank)) else $error("ext");
endmodule : abam_mapper_props
bind abam_mapper abam_mapper_props u_abam_mapper_props (
	.core_clk(core_clk),
	.rst_n(rst_n),
	.req(req),
	.bank_select_value(bank_select_value),
	.extended_instruction_set_enable(extended_instruction_set_enable),
	.index_bank(index_bank),
	.data_addr(data_addr),
	.rvalid(rvalid)
);
`default_nettype wire

// File: dv/abam_mapper_tb.sv
// Self-checking bench for the mapper.
`timescale 1ns/1ps
`default_nettype none
module abam_mapper_tb;
	logic core_clk = 0, rst_n = 0, extended_instruction_set_enable = 0, rvalid;
	abam_pkg::abam_bank_t bank_select_value = 4'h0, index_bank = 4'h3;
	abam_pkg::abam_req_s req;
	abam_pkg::abam_addr_t data_addr;
	abam_pkg::abam_data_t rdata;
	int bad_count = 0, n_compared = 0;
	always #5 core_clk = ~core_clk;
	abam_core_model u_abam_core_model (.core_clk(core_clk), .req(req));
	abam_mapper u_abam_mapper (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.req(req),
		.bank_select_value(bank_select_value),
		.extended_instruction_set_enable(extended_instruction_set_enable),
		.index_bank(index_bank),
		.data_addr(data_addr),
		.rdata(rdata),
		.rvalid(rvalid)
	);
	task automatic chk(input string n, input logic [11:0] e, g);
		n_compared++;
		if (g !== e)
		begin
			bad_count++;
			$display("FAIL %s exp %h got %h", n, e, g);
		end
	endtask : chk
	task automatic chk_data(input string n, input abam_pkg::abam_data_t e, g);
		n_compared++;
		if (g !== e)
		begin
			bad_count++;
			$display("FAIL %s exp %h got %h", n, e, g);
		end
	endtask : chk_data
	task automatic chk_flag(input string n, input logic e, g);
		n_compared++;
		if (g !== e)
		begin
			bad_count++;
			$display("FAIL %s exp %b got %b", n, e, g);
		end
	endtask : chk_flag
	// Bank in a[11:8] is driven even in access mode, where it must be ignored.
	task automatic op(input logic s, w, input logic [11:0] a, input abam_pkg::abam_data_t d);
		bank_select_value = a[11:8];
		u_abam_core_model.put('{1'b1, s, w, a[7:0], d});
		u_abam_core_model.put('0);
	endtask : op
	task automatic t_access;
		op(0, 0, 12'h900, 8'h00);
		chk("addr", 12'h000, data_addr);
		chk_flag("rvalid", 1'b1, rvalid);
		op(0, 0, 12'h95f, 8'h00);
		chk("addr", 12'h05f, data_addr);
		op(0, 0, 12'h960, 8'h00);
		chk("addr", 12'hf60, data_addr);
		op(0, 0, 12'h9ff, 8'h00);
		chk("addr", 12'hfff, data_addr);
		extended_instruction_set_enable = 1;
		op(0, 0, 12'h921, 8'h00);
		chk("addr", 12'h321, data_addr);
		index_bank = 4'hc;
		op(0, 0, 12'h921, 8'h00);
		chk("addr", 12'hc21, data_addr);
		op(0, 0, 12'h965, 8'h00);
		chk("addr", 12'hf65, data_addr);
		extended_instruction_set_enable = 0;
	endtask : t_access
	task automatic t_ram;
		op(1, 1, 12'h012, 8'hc3);
		chk("addr", 12'h012, data_addr);
		chk_flag("rvalid", 1'b0, rvalid);
		op(0, 0, 12'h712, 8'h00);
		chk_data("rdata", 8'hc3, rdata);
		chk_flag("rvalid", 1'b1, rvalid);
		op(1, 1, 12'ha34, 8'h5a);
		chk("addr", 12'ha34, data_addr);
		op(0, 1, 12'h265, 8'h96);
		chk("addr", 12'hf65, data_addr);
		op(1, 0, 12'hf65, 8'h00);
		chk_data("rdata", 8'h96, rdata);
		op(1, 0, 12'ha34, 8'h00);
		chk_data("rdata", 8'h5a, rdata);
		rst_n = 0;
		repeat (3) @(negedge core_clk);
		rst_n = 1;
		chk("addr", 12'h000, data_addr);
		chk_flag("rvalid", 1'b0, rvalid);
		op(1, 0, 12'h012, 8'h00);
		chk_data("rdata", 8'hc3, rdata);
		op(1, 0, 12'ha34, 8'h00);
		chk_data("rdata", 8'h5a, rdata);
	endtask : t_ram
	task automatic summarize;
		if (bad_count == 0 && n_compared > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : summarize
	initial
	begin
		repeat (16) @(negedge core_clk);
		rst_n = 1;
		t_access;
		t_ram;
		summarize;
	end
	// The tests need about 50 cycles; 500 cycles leave ample margin.
	initial
	begin
		#5000;
		bad_count++;
		summarize;
	end
endmodule : abam_mapper_tb
`default_nettype wire

// File: verilog/abam_map.svh
// Address constants for the access bank address mapper.
`ifndef ABAM_MAP_SVH
`define ABAM_MAP_SVH

`define ABAM_ACCESS_SPLIT 8'h60
`define ABAM_GPR_BANK 4'h0
`define ABAM_SFR_BANK 4'hf
`define ABAM_RAM_BASE 12'h000
`define ABAM_RAM_WORDS 4096
`define ABAM_INDEX_BANK 4'h0

`endif

// File: verilog/abam_mapper.sv
// Access bank address mapper with its data memory.
`timescale 1ns/1ps
`default_nettype none
`include "abam_map.svh"
module abam_mapper (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// Core operand request
	input wire abam_pkg::abam_req_s req,
	// Bank selection
	input wire abam_pkg::abam_bank_t bank_select_value,
	// Extended instruction set
	input wire logic extended_instruction_set_enable,
	input wire abam_pkg::abam_bank_t index_bank,
	// Result
	output var abam_pkg::abam_addr_t data_addr,
	output var abam_pkg::abam_data_t rdata,
	output var logic rvalid
);

	// ----------------------------------------
	// Declarations
	// ----------------------------------------
	abam_pkg::abam_state_s st_r;
	abam_pkg::abam_state_s st_nxt;
	abam_pkg::abam_bank_t acc_bank;
	abam_pkg::abam_addr_t banked_addr;
	abam_pkg::abam_addr_t access_addr;
	wire abam_pkg::abam_addr_t addr_c;
	logic req_take;
	logic req_rd;
	logic req_wr;
	logic req_banked;
	logic low_region;
	logic high_region;
	logic ram_we;

	// ----------------------------------------
	// Request decode
	// ----------------------------------------
	// A request is taken on every edge that sees valid high; nothing is refused.
	always_comb
	begin
		req_take = req.valid;
		req_rd = req.valid & ~req.write;
		req_wr = req.valid & req.write;
		req_banked = req.access_sel;
	end

	// ----------------------------------------
	// Access bank regions
	// ----------------------------------------
	// Split at 60h keeps the two access regions contiguous.
	always_comb
	begin
		low_region = 1'b0;
		high_region = 1'b0;
		if (req.offset < `ABAM_ACCESS_SPLIT)
		begin
			low_region = 1'b1;
		end
		else
		begin
			high_region = 1'b1;
		end
	end

	// The index bank input stands in for the other mapping of the extended set.
	always_comb
	begin
		acc_bank = `ABAM_SFR_BANK;
		case ({low_region, high_region})
			2'h2:
			begin
				if (extended_instruction_set_enable)
				begin
					acc_bank = index_bank;
				end
				else
				begin
					acc_bank = `ABAM_GPR_BANK;
				end
			end
			2'h1:
			begin
				acc_bank = `ABAM_SFR_BANK;
			end
			default:
			begin
				// Exactly one region flag is set, so this is a safe fallback only.
				acc_bank = `ABAM_SFR_BANK;
			end
		endcase
	end

	// ----------------------------------------
	// Address candidates
	// ----------------------------------------
	always_comb
	begin
		banked_addr = {bank_select_value, req.offset};
	end

	// Bank value is ignored so no bank update is needed first.
	always_comb
	begin
		access_addr = {acc_bank, req.offset};
	end

	// ----------------------------------------
	// Address select
	// ----------------------------------------
	// One multiplexer per address bit, steered by the access-select bit.
	for (genvar i = 0; i < $bits(abam_pkg::abam_addr_t); i++)
	begin : g_addr_bit
		assign addr_c[i] = req_banked ? banked_addr[i] : access_addr[i];
	end

	// ----------------------------------------
	// Request acceptance
	// ----------------------------------------
	// Every request moves the address; only a read raises the data pulse.
	function automatic abam_pkg::abam_state_s take_req(
		input abam_pkg::abam_state_s cur,
		input abam_pkg::abam_addr_t addr,
		input logic rd
	);
		abam_pkg::abam_state_s nxt;
		nxt = cur;
		nxt.addr = addr;
		nxt.rvalid = rd;
		if (rd)
		begin
			nxt.state = abam_pkg::ABAM_READ;
		end
		else
		begin
			// Writes return no data, so the next state is idle.
			nxt.state = abam_pkg::ABAM_IDLE;
		end
		return nxt;
	endfunction : take_req

	// ----------------------------------------
	// State update
	// ----------------------------------------
	always_comb
	begin
		st_nxt = st_r;
		st_nxt.rvalid = 1'b0;
		case (st_r.state)
			abam_pkg::ABAM_IDLE:
			begin
				if (req_rd)
				begin
					st_nxt = take_req(st_r, addr_c, 1'b1);
				end
				else if (req_take)
				begin
					st_nxt = take_req(st_r, addr_c, 1'b0);
				end
			end
			abam_pkg::ABAM_READ:
			begin
				if (req_rd)
				begin
					st_nxt = take_req(st_r, addr_c, 1'b1);
				end
				else if (req_take)
				begin
					st_nxt = take_req(st_r, addr_c, 1'b0);
				end
				else
				begin
					st_nxt.state = abam_pkg::ABAM_IDLE;
				end
			end
			default:
			begin
				st_nxt.state = abam_pkg::ABAM_IDLE;
			end
		endcase
	end

	// Reset returns the state to idle and clears the address and the pulse; the RAM is left alone.
	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
		begin
			st_r <= '{state: abam_pkg::ABAM_IDLE, addr: `ABAM_RAM_BASE, rvalid: 1'b0};
		end
		else
		begin
			st_r <= st_nxt;
		end
	end

	// ----------------------------------------
	// Data memory
	// ----------------------------------------
	always_comb
	begin
		ram_we = req_wr;
	end

	// RAM index equals the data address, so RAM starts at 000h and grows up.
	abam_ram u_ram (
		.core_clk(core_clk),
		.we(ram_we),
		.addr(addr_c),
		.wdata(req.wdata),
		.rdata(rdata)
	);

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	// Both come straight from the state register, so they never glitch.
	assign data_addr = st_r.addr;
	assign rvalid = st_r.rvalid;

endmodule : abam_mapper
`default_nettype wire

// File: verilog/abam_pkg.sv
// Types shared by the access bank address mapper.
`default_nettype none
`include "abam_map.svh"
package abam_pkg;

	typedef logic [3:0] abam_bank_t;
	typedef logic [7:0] abam_off_t;
	typedef logic [11:0] abam_addr_t;
	typedef logic [7:0] abam_data_t;

	typedef struct packed {
		logic valid;
		logic access_sel;
		logic write;
		abam_off_t offset;
		abam_data_t wdata;
	} abam_req_s;

	typedef enum logic [1:0] {
		ABAM_IDLE = 2'h0,
		ABAM_READ = 2'h1
	} abam_state_e;

	typedef struct packed {
		abam_state_e state;
		abam_addr_t addr;
		logic rvalid;
	} abam_state_s;

endpackage : abam_pkg
`default_nettype wire

// File: verilog/abam_ram.sv
// General purpose RAM array with registered read data.
`timescale 1ns/1ps
`default_nettype none
`include "abam_map.svh"
module abam_ram (
	// Clock
	input wire logic core_clk,
	// Access port
	input wire logic we,
	input wire abam_pkg::abam_addr_t addr,
	input wire abam_pkg::abam_data_t wdata,
	output var abam_pkg::abam_data_t rdata
);

	abam_pkg::abam_data_t mem [0:`ABAM_RAM_WORDS-1];

	// No reset reaches the array, so contents survive every reset source.
	always_ff @(posedge core_clk)
	begin
		if (we)
		begin
			mem[addr] <= wdata;
		end
		rdata <= mem[addr];
	end

endmodule : abam_ram
`default_nettype wire
